// File: hdl/adsr_pkg.sv
// Package: constants, types and register layout of the analog die control slice
package adsr_pkg;
   // ============================================================
   // Register addresses (5-bit index)
   localparam logic [4:0] ADDR_IMR = 5'h04;
   localparam logic [4:0] ADDR_IFR = 5'h05;
   localparam logic [4:0] ADDR_RMR = 5'h06;
   localparam logic [4:0] ADDR_SYSTEM_STATUS_REG = 5'h0C;
   // ============================================================
   // Enable and flag bit positions
   localparam int BIT_BUS_EDGE = 5;
   localparam int BIT_OVERTEMP = 4;
   localparam int BIT_UNDERVOLT = 3;
   localparam int BIT_OVERVOLT = 2;
   localparam int BIT_OVERCURRENT = 1;
   localparam int BIT_LOW_TEMP_THRESHOLD_TEST = 7;
   localparam int BIT_OVERVOLT_RESET_ENABLE = 1;
   localparam int BIT_OVERTEMP_RESET_ENABLE = 0;
   localparam int BIT_ST_LINCL = 6;
   localparam int BIT_ST_SWITCHED_SUPPLY_OUTPUT_OC = 5;
   localparam int BIT_ST_UNDERVOLT = 3;
   localparam int BIT_ST_OVERVOLT = 2;
   localparam int BIT_ST_HB_OC = 1;
   localparam int BIT_ST_OVERTEMP = 0;
   // ============================================================
   // Frame layout and counts
   localparam int FRAME_RW_BIT = 15;
   localparam int FRAME_PAR_LSB = 9;
   localparam logic [4:0] FRAME_EDGES = 5'h10;
   localparam logic [4:0] PARITY_EDGE_BEFORE = 5'h06;
   localparam logic [4:0] COUNT_MAX = 5'h1F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [4:0] ENABLE_RESET = 5'h00;
   localparam logic [2:0] RMR_RESET = 3'h0;
   localparam int FLAG_COUNT = 6;
   // ============================================================
   // Types
   typedef enum logic [0:0] {
      SPI_IDLE = 1'b0,
      SPI_ACTIVE = 1'b1
   } adsr_spi_state_type;

   typedef struct packed {
      logic overtemp;
      logic undervolt;
      logic overvolt;
      logic hb_overcurrent;
      logic switched_supply_output_overcurrent;
      logic logic_supply_low;
      logic watchdog_timeout;
      logic watchdog_wake;
      logic stop_mode;
      logic lin_current_limit;
   } adsr_cond_type;

   typedef struct packed {
      logic ss_n;
      logic sclk;
      logic mosi;
      logic lin;
      logic rst_n;
   } adsr_link_type;

   // Serial clock idles low, so its synchroniser starts low to avoid a false edge
   localparam adsr_link_type LINK_IDLE = 5'h13;
   localparam adsr_cond_type COND_IDLE = 10'h000;

   // Even parity over direction, address and parity bits
   function automatic logic parity_ok(input logic [6:0] bits);
      return ~(^bits);
   endfunction
endpackage

// File: hdl/adsr_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module adsr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_q;

   always_comb begin
      next_stage1 = d;
      next_q = stage1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= INIT;
         q <= INIT;
      end else begin
         stage1 <= next_stage1;
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

// File: hdl/adsr_flag.sv
// Sticky event flag: set wins over a write-one clear
`timescale 1ns/1ps
`default_nettype none
module adsr_flag (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic soft_clear,
   input wire logic set,
   input wire logic clear,
   output logic flag
);
   logic next_flag;

   always_comb begin
      // A persisting condition keeps setting, so a write-one clear cannot drop it
      if (soft_clear) begin
         next_flag = 1'b0;
      end else if (set) begin
         next_flag = 1'b1;
      end else if (clear) begin
         next_flag = 1'b0;
      end else begin
         next_flag = flag;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end
endmodule
`default_nettype wire

// File: hdl/adsr_top.sv
// Analog die control slice: SPI slave, interrupt flags and masks, reset routing
`timescale 1ns/1ps
`default_nettype none
module adsr_top
   import adsr_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic SS_N,
   input wire logic SCLK,
   input wire logic MOSI,
   output logic MISO,
   output logic MISO_OE,
   input wire logic LIN_RX,
   input wire logic OVERTEMP,
   input wire logic UNDERVOLT,
   input wire logic OVERVOLT,
   input wire logic HB_OVERCURRENT,
   input wire logic SWITCHED_SUPPLY_OUTPUT_OVERCURRENT,
   input wire logic LOGIC_SUPPLY_LOW,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic WATCHDOG_WAKE,
   input wire logic STOP_MODE,
   input wire logic LIN_CURRENT_LIMIT,
   input wire logic RST_PIN_IN,
   output logic RST_PIN_OUT,
   output logic RST_PIN_OE,
   output logic IRQ_PIN_OUT,
   output logic IRQ_PIN_OE,
   output logic INTERNAL_RESET,
   output logic WAKE_MCU,
   output logic WAKE_REGULATOR,
   output logic LOW_TEMP_THRESHOLD
);
   // ============================================================
   // Input synchronisers
   adsr_link_type link_raw;
   adsr_link_type link_s;
   adsr_cond_type cond_raw;
   adsr_cond_type cond;

   assign link_raw = '{ss_n: SS_N, sclk: SCLK, mosi: MOSI, lin: LIN_RX, rst_n: RST_PIN_IN};
   assign cond_raw = '{overtemp: OVERTEMP, undervolt: UNDERVOLT, overvolt: OVERVOLT,
                       hb_overcurrent: HB_OVERCURRENT, switched_supply_output_overcurrent: SWITCHED_SUPPLY_OUTPUT_OVERCURRENT,
                       logic_supply_low: LOGIC_SUPPLY_LOW, watchdog_timeout: WATCHDOG_TIMEOUT,
                       watchdog_wake: WATCHDOG_WAKE, stop_mode: STOP_MODE,
                       lin_current_limit: LIN_CURRENT_LIMIT};

   adsr_sync #(.W($bits(adsr_link_type)), .INIT(LINK_IDLE)) u_link_sync (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d(link_raw),
      .q(link_s)
   );

   adsr_sync #(.W($bits(adsr_cond_type)), .INIT(COND_IDLE)) u_cond_sync (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d(cond_raw),
      .q(cond)
   );

   // ============================================================
   // Edge detection on synchronised levels
   logic prev_sclk;
   logic prev_lin;
   logic next_prev_sclk;
   logic next_prev_lin;
   logic sclk_rise;
   logic sclk_fall;
   logic lin_fall;
   logic soft_reset;

   assign sclk_rise = ~prev_sclk & link_s.sclk;
   assign sclk_fall = prev_sclk & ~link_s.sclk;
   assign lin_fall = prev_lin & ~link_s.lin;
   assign soft_reset = ~link_s.rst_n;

   always_comb begin
      next_prev_sclk = link_s.sclk;
      next_prev_lin = link_s.lin;
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_sclk <= 1'b0;
         prev_lin <= 1'b1;
      end else begin
         prev_sclk <= next_prev_sclk;
         prev_lin <= next_prev_lin;
      end
   end

   // ============================================================
   // Flags and status byte
   logic [4:0] irq_enable;
   logic [2:0] reset_mask;
   logic [FLAG_COUNT-1:0] flag_set;
   logic [FLAG_COUNT-1:0] flag_clear;
   logic [FLAG_COUNT-1:0] flag;
   logic bus_edge_flag;
   logic overtemp_flag;
   logic undervolt_flag;
   logic overvolt_flag;
   logic hb_oc_flag;
   logic switched_supply_output_oc_flag;
   logic overcurrent_flag;
   logic [7:0] status_byte;
   logic [7:0] flags_byte;
   logic [7:0] imr_byte;
   logic [7:0] rmr_byte;
   logic wr_strobe;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;

   assign flag_set = {lin_fall, cond.overtemp, cond.undervolt, cond.overvolt,
                      cond.hb_overcurrent, cond.switched_supply_output_overcurrent};
   assign bus_edge_flag = flag[5];
   assign overtemp_flag = flag[4];
   assign undervolt_flag = flag[3];
   assign overvolt_flag = flag[2];
   assign hb_oc_flag = flag[1];
   assign switched_supply_output_oc_flag = flag[0];
   assign overcurrent_flag = hb_oc_flag | switched_supply_output_oc_flag;

   always_comb begin
      flag_clear = '0;
      if (wr_strobe && wr_addr == ADDR_IFR) begin
         flag_clear[5] = wr_data[BIT_BUS_EDGE];
         flag_clear[4] = wr_data[BIT_OVERTEMP];
         flag_clear[3] = wr_data[BIT_UNDERVOLT];
         flag_clear[2] = wr_data[BIT_OVERVOLT];
      end
      if (wr_strobe && wr_addr == ADDR_SYSTEM_STATUS_REG) begin
         flag_clear[1] = wr_data[BIT_ST_HB_OC];
         flag_clear[0] = wr_data[BIT_ST_SWITCHED_SUPPLY_OUTPUT_OC];
      end
   end

   generate
      for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
         adsr_flag u_flag (
            .clk(REF_CLK),
            .arst_n(ARST_N),
            .soft_clear(soft_reset),
            .set(flag_set[i]),
            .clear(flag_clear[i]),
            .flag(flag[i])
         );
      end
   endgenerate

   always_comb begin
      status_byte = BYTE_ZERO;
      status_byte[BIT_ST_LINCL] = cond.lin_current_limit;
      status_byte[BIT_ST_SWITCHED_SUPPLY_OUTPUT_OC] = switched_supply_output_oc_flag;
      status_byte[BIT_ST_UNDERVOLT] = undervolt_flag;
      status_byte[BIT_ST_OVERVOLT] = overvolt_flag;
      status_byte[BIT_ST_HB_OC] = hb_oc_flag;
      status_byte[BIT_ST_OVERTEMP] = overtemp_flag;
      flags_byte = BYTE_ZERO;
      flags_byte[BIT_BUS_EDGE] = bus_edge_flag;
      flags_byte[BIT_OVERTEMP] = overtemp_flag;
      flags_byte[BIT_UNDERVOLT] = undervolt_flag;
      flags_byte[BIT_OVERVOLT] = overvolt_flag;
      flags_byte[BIT_OVERCURRENT] = overcurrent_flag;
      imr_byte = BYTE_ZERO;
      imr_byte[BIT_BUS_EDGE:BIT_OVERCURRENT] = irq_enable;
      rmr_byte = BYTE_ZERO;
      rmr_byte[BIT_LOW_TEMP_THRESHOLD_TEST] = reset_mask[2];
      rmr_byte[BIT_OVERVOLT_RESET_ENABLE] = reset_mask[1];
      rmr_byte[BIT_OVERTEMP_RESET_ENABLE] = reset_mask[0];
   end

   // ============================================================
   // Enable and reset mask registers
   logic [4:0] next_irq_enable;
   logic [2:0] next_reset_mask;

   always_comb begin
      next_irq_enable = irq_enable;
      next_reset_mask = reset_mask;
      if (soft_reset) begin
         next_irq_enable = ENABLE_RESET;
         next_reset_mask = RMR_RESET;
      end else if (wr_strobe && wr_addr == ADDR_IMR) begin
         next_irq_enable = wr_data[BIT_BUS_EDGE:BIT_OVERCURRENT];
      end else if (wr_strobe && wr_addr == ADDR_RMR) begin
         next_reset_mask = {wr_data[BIT_LOW_TEMP_THRESHOLD_TEST], wr_data[BIT_OVERVOLT_RESET_ENABLE], wr_data[BIT_OVERTEMP_RESET_ENABLE]};
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_enable <= ENABLE_RESET;
         reset_mask <= RMR_RESET;
      end else begin
         irq_enable <= next_irq_enable;
         reset_mask <= next_reset_mask;
      end
   end

   // ============================================================
   // SPI slave engine
   adsr_spi_state_type spi_state;
   adsr_spi_state_type next_spi_state;
   logic [4:0] fall_cnt;
   logic [4:0] rise_cnt;
   logic [15:0] frame_in;
   logic [15:0] frame_out;
   logic [4:0] next_fall_cnt;
   logic [4:0] next_rise_cnt;
   logic [15:0] next_frame_in;
   logic [15:0] next_frame_out;
   logic next_miso;
   logic next_miso_oe;
   logic [7:0] read_data;

   assign wr_addr = frame_in[FRAME_RW_BIT-1:FRAME_PAR_LSB+1];
   assign wr_data = frame_in[7:0];
   // Count saturates, so 32 or more edges can never alias to sixteen
   assign wr_strobe = (spi_state == SPI_ACTIVE) && link_s.ss_n && fall_cnt == FRAME_EDGES
                      && !frame_in[FRAME_RW_BIT]
                      && parity_ok(frame_in[FRAME_RW_BIT:FRAME_PAR_LSB]);

   always_comb begin
      unique case (frame_in[4:0])
         ADDR_IMR: read_data = imr_byte;
         ADDR_IFR: read_data = flags_byte;
         ADDR_RMR: read_data = rmr_byte;
         ADDR_SYSTEM_STATUS_REG: read_data = status_byte;
         default: read_data = BYTE_ZERO;
      endcase
   end

   always_comb begin
      next_spi_state = spi_state;
      next_fall_cnt = fall_cnt;
      next_rise_cnt = rise_cnt;
      next_frame_in = frame_in;
      next_frame_out = frame_out;
      next_miso = MISO;
      next_miso_oe = MISO_OE;
      unique case (spi_state)
         SPI_IDLE: begin
            next_miso_oe = 1'b0;
            if (!link_s.ss_n) begin
               next_spi_state = SPI_ACTIVE;
               next_fall_cnt = 5'h00;
               next_rise_cnt = 5'h00;
               next_frame_out = {status_byte, BYTE_ZERO};
               next_miso_oe = 1'b1;
               next_miso = 1'b1;
            end
         end
         SPI_ACTIVE: begin
            if (link_s.ss_n) begin
               next_spi_state = SPI_IDLE;
               next_miso_oe = 1'b0;
            end else begin
               if (sclk_rise) begin
                  if (rise_cnt < FRAME_EDGES) begin
                     next_miso = frame_out[~rise_cnt[3:0]];
                  end
                  if (rise_cnt != COUNT_MAX) begin
                     next_rise_cnt = rise_cnt + 5'h01;
                  end
               end
               if (sclk_fall) begin
                  next_frame_in = {frame_in[14:0], link_s.mosi};
                  if (fall_cnt != COUNT_MAX) begin
                     next_fall_cnt = fall_cnt + 5'h01;
                  end
                  if (fall_cnt == PARITY_EDGE_BEFORE) begin
                     next_frame_out[7:0] = read_data;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         spi_state <= SPI_IDLE;
         fall_cnt <= 5'h00;
         rise_cnt <= 5'h00;
         frame_in <= 16'h0000;
         frame_out <= 16'h0000;
         MISO <= 1'b1;
         MISO_OE <= 1'b0;
      end else begin
         spi_state <= next_spi_state;
         fall_cnt <= next_fall_cnt;
         rise_cnt <= next_rise_cnt;
         frame_in <= next_frame_in;
         frame_out <= next_frame_out;
         MISO <= next_miso;
         MISO_OE <= next_miso_oe;
      end
   end

   // ============================================================
   // Interrupt, reset and wake-up outputs
   logic next_irq;
   logic next_int_reset;
   logic next_wake;

   always_comb begin
      // Wired-low pin, so a request only ever enables the pull-down
      next_irq = |({bus_edge_flag, overtemp_flag, undervolt_flag, overvolt_flag,
                    overcurrent_flag} & irq_enable);
      next_int_reset = cond.logic_supply_low
                       | (cond.overvolt & reset_mask[1])
                       | (cond.overtemp & reset_mask[0])
                       | cond.watchdog_timeout;
      next_wake = cond.stop_mode & ((lin_fall & irq_enable[4]) | cond.watchdog_wake
                                    | cond.logic_supply_low);
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ_PIN_OE <= 1'b0;
         RST_PIN_OE <= 1'b0;
         INTERNAL_RESET <= 1'b0;
         WAKE_MCU <= 1'b0;
         WAKE_REGULATOR <= 1'b0;
      end else begin
         IRQ_PIN_OE <= next_irq;
         RST_PIN_OE <= next_int_reset;
         INTERNAL_RESET <= next_int_reset;
         WAKE_MCU <= next_wake;
         WAKE_REGULATOR <= next_wake;
      end
   end

   assign IRQ_PIN_OUT = 1'b0;
   assign RST_PIN_OUT = 1'b0;
   assign LOW_TEMP_THRESHOLD = reset_mask[2];
endmodule
`default_nettype wire

// File: testbench/adsr_props.sv
// Checker: port-level timing relations of the control slice
`timescale 1ns/1ps
`default_nettype none
module adsr_props (
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic SS_N,
   input wire logic SCLK,
   input wire logic MISO,
   input wire logic MISO_OE,
   input wire logic LOGIC_SUPPLY_LOW,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic STOP_MODE,
   input wire logic RST_PIN_OE,
   input wire logic IRQ_PIN_OE,
   input wire logic INTERNAL_RESET,
   input wire logic WAKE_MCU,
   input wire logic WAKE_REGULATOR
);
   // ============================================================
   // Port relations
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);
   chk_float_deselected: assert property (SS_N [*5] |-> !MISO_OE)
      else $error("data out still driven while deselected");
   chk_frame_drive: assert property ($fell(SS_N) |-> ##[3:4] MISO_OE)
      else $error("data out not driven after select fall");
   chk_miso_hold: assert property ((!SCLK && MISO_OE && !SS_N) [*3] |=> $stable(MISO))
      else $error("data out changed without a clock rise");
   chk_logic_low_reset: assert property (LOGIC_SUPPLY_LOW [*4] |=> RST_PIN_OE)
      else $error("logic supply low did not pull reset");
   chk_watchdog_reset: assert property (WATCHDOG_TIMEOUT [*4] |=> INTERNAL_RESET)
      else $error("watchdog timeout gave no reset");
   chk_reset_pin_same: assert property (INTERNAL_RESET == RST_PIN_OE)
      else $error("internal reset and reset pin differ");
   chk_wake_pair: assert property (WAKE_MCU == WAKE_REGULATOR)
      else $error("controller and regulator wake differ");
   chk_wake_stop_only: assert property (!STOP_MODE [*4] |=> !WAKE_MCU)
      else $error("wake raised outside stop");
   chk_irq_quiet: assert property ($rose(ARST_N) |-> !IRQ_PIN_OE [*8])
      else $error("interrupt raised right after reset");
endmodule

bind adsr_top adsr_props adsr_props_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SS_N(SS_N), .SCLK(SCLK),
   .MISO(MISO), .MISO_OE(MISO_OE), .LOGIC_SUPPLY_LOW(LOGIC_SUPPLY_LOW), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
   .STOP_MODE(STOP_MODE), .RST_PIN_OE(RST_PIN_OE), .IRQ_PIN_OE(IRQ_PIN_OE), .INTERNAL_RESET(INTERNAL_RESET),
   .WAKE_MCU(WAKE_MCU), .WAKE_REGULATOR(WAKE_REGULATOR));
`default_nettype wire

// File: testbench/adsr_master.sv
// Partner: serial master on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module adsr_master (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_oe,
   output logic ss_n,
   output logic sclk,
   output logic mosi
);
   logic oe_lost;
   initial begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      oe_lost = 1'b0;
   end
   // ============================================================
   // One frame of n sample edges; half period 4 clocks
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk);
      ss_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         mosi <= (i < 16) ? tx[15 - i] : 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (3) @(posedge clk);
         // Sampled late in the low phase, data out lags the rise by sync
         @(negedge clk);
         rx = {rx[14:0], miso};
         if (miso_oe !== 1'b1) oe_lost = 1'b1;
         @(posedge clk);
      end
      ss_n <= 1'b1;
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: testbench/adsr_top_tb_top.sv
// Testbench: frames, flags, masks and reset routing of the control slice
`timescale 1ns/1ps
`default_nettype none
module adsr_top_tb_top;
   import adsr_pkg::*;
   logic ref_clk, arst_n, lin_rx, mcu_pull, saw_rst, saw_wake;
   logic ss_n, sclk, mosi, miso, miso_oe, rst_out, rst_oe, irq_out, irq_oe, int_rst, wake_mcu, wake_reg, low_thr;
   logic [15:0] p;
   adsr_cond_type cond;
   int fail_count, n_compared;
   logic [7:0] fbit [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h02};
   logic [7:0] sbit [5] = '{8'h01, 8'h08, 8'h04, 8'h02, 8'h20};
   // Open-drain reset wire with pull-up
   wire logic rst_wire = ~(rst_oe | mcu_pull);
   adsr_top adsr_top_inst (.REF_CLK(ref_clk), .ARST_N(arst_n), .SS_N(ss_n), .SCLK(sclk), .MOSI(mosi),
      .MISO(miso), .MISO_OE(miso_oe), .LIN_RX(lin_rx), .OVERTEMP(cond.overtemp), .UNDERVOLT(cond.undervolt),
      .OVERVOLT(cond.overvolt), .HB_OVERCURRENT(cond.hb_overcurrent), .SWITCHED_SUPPLY_OUTPUT_OVERCURRENT(cond.switched_supply_output_overcurrent),
      .LOGIC_SUPPLY_LOW(cond.logic_supply_low), .WATCHDOG_TIMEOUT(cond.watchdog_timeout),
      .WATCHDOG_WAKE(cond.watchdog_wake), .STOP_MODE(cond.stop_mode), .LIN_CURRENT_LIMIT(cond.lin_current_limit),
      .RST_PIN_IN(rst_wire), .RST_PIN_OUT(rst_out), .RST_PIN_OE(rst_oe), .IRQ_PIN_OUT(irq_out),
      .IRQ_PIN_OE(irq_oe), .INTERNAL_RESET(int_rst), .WAKE_MCU(wake_mcu), .WAKE_REGULATOR(wake_reg),
      .LOW_TEMP_THRESHOLD(low_thr));
   adsr_master adsr_master_inst (.clk(ref_clk), .miso(miso), .miso_oe(miso_oe), .ss_n(ss_n), .sclk(sclk),
      .mosi(mosi));
   // ============================================================
   // Clock, monitors, watchdog
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (int_rst === 1'b1) saw_rst <= 1'b1;
      if (wake_mcu === 1'b1 && wake_reg === 1'b1) saw_wake <= 1'b1;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      close_out();
   end
   // ============================================================
   // Tasks
   task automatic close_out;
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bit_is(input string what, input logic s, input logic e);
      check(what, {15'h0, s}, {15'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   function automatic logic [7:0] cmd(input logic rw, input logic [4:0] a, input logic bad);
      return {rw, a, ^{rw, a} ^ bad, 1'b0};
   endfunction
   task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [15:0] rx);
      adsr_master_inst.xfer({cmd(1'b0, a, 1'b0), d}, 16, rx);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input bit full);
      logic [15:0] rx;
      adsr_master_inst.xfer({cmd(1'b1, a, 1'b0), 8'h5A}, 16, rx);
      if (full) check("status read", rx, {exp, exp});
      else check($sformatf("register %h", a), {8'h00, rx[7:0]}, {8'h00, exp});
   endtask
   task automatic setc(input int i, input logic v);
      case (i)
         0: cond.overtemp <= v;
         1: cond.undervolt <= v;
         2: cond.overvolt <= v;
         3: cond.hb_overcurrent <= v;
         4: cond.switched_supply_output_overcurrent <= v;
         5: cond.logic_supply_low <= v;
         6: cond.watchdog_timeout <= v;
         8: cond.stop_mode <= v;
         9: cond.lin_current_limit <= v;
         default: cond.watchdog_wake <= v;
      endcase
   endtask
   task automatic lin_fall;
      lin_rx <= 1'b0;
      tick(6);
      lin_rx <= 1'b1;
      tick(6);
   endtask
   // ============================================================
   // Sequence
   initial begin
      arst_n = 1'b0;
      lin_rx = 1'b1;
      mcu_pull = 1'b0;
      saw_rst = 1'b0;
      saw_wake = 1'b0;
      cond = COND_IDLE;
      fail_count = 0;
      n_compared = 0;
      tick(10);
      arst_n <= 1'b1;
      tick(4);
      rd(ADDR_IMR, 8'h00, 0);
      rd(ADDR_IFR, 8'h00, 0);
      rd(ADDR_RMR, 8'h00, 0);
      rd(ADDR_SYSTEM_STATUS_REG, 8'h00, 1);
      wr(ADDR_IMR, 8'h3E, p);
      rd(ADDR_IMR, 8'h3E, 0);
      adsr_master_inst.xfer({cmd(1'b0, ADDR_IMR, 1'b1), 8'h00}, 16, p);
      adsr_master_inst.xfer({cmd(1'b0, ADDR_IMR, 1'b0), 8'h00}, 15, p);
      adsr_master_inst.xfer({cmd(1'b0, ADDR_IMR, 1'b0), 8'h00}, 17, p);
      rd(ADDR_IMR, 8'h3E, 0);
      adsr_master_inst.xfer({cmd(1'b0, ADDR_IMR, 1'b0) | 8'h01, 8'h14}, 16, p);
      adsr_master_inst.xfer({cmd(1'b1, ADDR_IMR, 1'b1), 8'h00}, 16, p);
      check("read with odd parity", p, 16'h0014);
      wr(5'h08, 8'hFF, p);
      rd(5'h08, 8'h00, 0);
      wr(ADDR_IMR, 8'h3E, p);
      check("write returns prior", p, 16'h0014);
      bit_is("master lost data out", adsr_master_inst.oe_lost, 1'b0);
      lin_fall();
      rd(ADDR_IFR, 8'h20, 0);
      bit_is("irq bus edge", irq_oe, 1'b1);
      wr(ADDR_IFR, 8'h00, p);
      rd(ADDR_IFR, 8'h20, 0);
      wr(ADDR_IMR, 8'h1E, p);
      bit_is("irq edge disabled", irq_oe, 1'b0);
      wr(ADDR_IFR, 8'h20, p);
      rd(ADDR_IFR, 8'h00, 0);
      wr(ADDR_IMR, 8'h3E, p);
      for (int i = 0; i < 5; i++) begin
         setc(i, 1'b1);
         tick(6);
         rd(ADDR_IFR, fbit[i], 0);
         bit_is("irq condition", irq_oe, 1'b1);
         if (i < 3) rd(ADDR_SYSTEM_STATUS_REG, sbit[i], 1);
         wr(ADDR_IFR, fbit[i], p);
         setc(i, 1'b0);
         tick(6);
         if (i > 2) wr(ADDR_IFR, fbit[i], p);
         rd(ADDR_IFR, fbit[i], 0);
         wr(i < 3 ? ADDR_IFR : ADDR_SYSTEM_STATUS_REG, sbit[i] & fbit[i] | (i < 3 ? fbit[i] : sbit[i]), p);
         rd(ADDR_IFR, 8'h00, 0);
         bit_is("irq cleared", irq_oe, 1'b0);
      end
      setc(9, 1'b1);
      tick(6);
      rd(ADDR_SYSTEM_STATUS_REG, 8'h40, 1);
      setc(9, 1'b0);
      wr(ADDR_RMR, 8'h80, p);
      rd(ADDR_RMR, 8'h80, 0);
      bit_is("low threshold", low_thr, 1'b1);
      bit_is("reset pin level", rst_out, 1'b0);
      bit_is("irq pin level", irq_out, 1'b0);
      saw_rst <= 1'b0;
      setc(2, 1'b1);
      tick(10);
      bit_is("masked overvolt reset", saw_rst, 1'b0);
      setc(2, 1'b0);
      for (int j = 0; j < 2; j++) begin
         wr(ADDR_RMR, j == 0 ? 8'h01 : 8'h02, p);
         saw_rst <= 1'b0;
         setc(j * 2, 1'b1);
         tick(10);
         setc(j * 2, 1'b0);
         tick(6);
         bit_is("enabled reset", saw_rst, 1'b1);
         rd(ADDR_RMR, 8'h00, 0);
      end
      for (int k = 5; k < 7; k++) begin
         setc(k, 1'b1);
         tick(8);
         bit_is("reset pin pulled", rst_oe, 1'b1);
         setc(k, 1'b0);
         tick(8);
      end
      wr(ADDR_IMR, 8'h3E, p);
      mcu_pull <= 1'b1;
      tick(6);
      mcu_pull <= 1'b0;
      tick(6);
      rd(ADDR_IMR, 8'h00, 0);
      setc(8, 1'b1);
      tick(6);
      saw_wake <= 1'b0;
      lin_fall();
      bit_is("wake edge masked", saw_wake, 1'b0);
      wr(ADDR_IMR, 8'h20, p);
      lin_fall();
      bit_is("wake on bus edge", saw_wake, 1'b1);
      saw_wake <= 1'b0;
      setc(7, 1'b1);
      tick(8);
      bit_is("wake on watchdog", saw_wake, 1'b1);
      setc(7, 1'b0);
      tick(8);
      close_out();
   end
endmodule
`default_nettype wire
